// *** ppt_link_model.sv ***
`default_nettype none
module ppt_link_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ppt_pkg::NUM_PATHS-1:0] want_sync,
	input wire logic [ppt_pkg::NUM_PATHS-1:0] want_err,
	output logic [ppt_pkg::NUM_PATHS-1:0] path_in_sync_state,
	output logic [ppt_pkg::NUM_PATHS-1:0] path_byte_err_det
);
	import ppt_pkg::*;
	// lock state follows the request a cycle late, as a real monitor would
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			path_in_sync_state <= '0;
		end else begin
			path_in_sync_state <= want_sync;
		end
	end
	// one pulse per errored byte; a held request means an error every byte
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			path_byte_err_det <= '0;
		end else begin
			path_byte_err_det <= want_err;
		end
	end
endmodule
`default_nettype wire

// *** ppt_path_test_ctrl.sv ***
// Summary of operation
// - generator triple bit n merges paths n+1, n+5, n+9 into one payload
// - generator full-concat bit makes all twelve slots one payload, overriding triples
// - monitor has its own triple and full-concat bits, same grouping and precedence
// - byte-error flag sets when path is in sync and an errored byte arrives
// - byte-error flag sets regardless of enable, clears on status read
// - byte-error enable lets that flag drive the interrupt output
// - sync-change flag sets on any in-sync to out-of-sync transition or back
// - sync-change flag sets regardless of enable, clears on read
// - sync-change enable lets that flag drive the interrupt output
// - read-only state bit shows each path's live in-sync state
// - any write to transfer trigger starts copying counters to holding registers
// - pending bit high from transfer start until holding registers are loaded
// - an output pin mirrors the transfer pending bit
// - any write to indirect address starts an indirect access with path and page
// - path codes 1 to 12 select paths, others select none
// - monitor pages: config, LFSR high, LFSR low, error count; others reserved
// - generator pages: config, LFSR high, LFSR low; 1011 reserved
// - select bit one reads RAM into data register, zero writes data into RAM
// - busy set on address write, cleared when the RAM access completes
// - error counters saturate at maximum and restart after each transfer
`default_nettype none
module ppt_path_test_ctrl (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [ppt_pkg::NUM_PATHS-1:0] path_in_sync_state,
	input wire logic [ppt_pkg::NUM_PATHS-1:0] path_byte_err_det,
	output var ppt_pkg::ppt_mode_type [ppt_pkg::NUM_PATHS-1:0] gen_path_mode,
	output var ppt_pkg::ppt_mode_type [ppt_pkg::NUM_PATHS-1:0] chk_path_mode,
	output logic irq_o,
	output logic counter_xfer_pending
);
	import ppt_pkg::*;

	logic req;
	logic wr;
	logic rd;
	logic [7:0] idx;
	logic [15:0] wmask;
	logic [15:0] gen_cfg_q;
	logic [15:0] mon_cfg_q;
	logic [NUM_PATHS-1:0] berr_en_q;
	logic [NUM_PATHS-1:0] sync_en_q;
	logic [NUM_PATHS-1:0] path_byte_err_flag;
	logic [NUM_PATHS-1:0] path_sync_change_flag;
	logic [NUM_PATHS-1:0] sync_prev_q;
	logic [NUM_PATHS-1:0] hit;
	logic [15:0] ram_page_select_q;
	logic [15:0] data_q;
	logic [15:0] rdv;
	logic tip_q;
	logic xfer_start;
	ppt_acc_type acc_q;
	logic acc_start;
	logic [3:0] path;
	logic [3:0] page;
	logic path_ok;
	logic page_ram;
	logic page_err;
	logic [6:0] ram_idx;
	logic [3:0] path_idx;
	logic [15:0] ram_q [NUM_PATHS*RAM_SLOTS];
	logic [15:0] cnt_q [NUM_PATHS];
	logic [15:0] hold_q [NUM_PATHS];

	// bus decode; one request per ack, ack drops the cycle after it is given
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = req & wb_we_i;
	assign rd = req & ~wb_we_i;
	assign idx = wb_adr_i[9:2];
	assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] m);
		return (old & ~(wmask & m)) | (wb_dat_i[15:0] & wmask & m);
	endfunction

	// single-cycle ack, registered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// software-written configuration and enables
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gen_cfg_q <= RST16;
			mon_cfg_q <= RST16;
			berr_en_q <= '0;
			sync_en_q <= '0;
		end else if (wr) begin
			unique case (idx)
				IDX_GEN_CFG: gen_cfg_q <= merge(gen_cfg_q, GEN_CFG_MASK);
				IDX_MON_CFG: mon_cfg_q <= merge(mon_cfg_q, MON_CFG_MASK);
				IDX_BERR_EN: berr_en_q <= 12'(merge({4'h0, berr_en_q}, 16'h0fff));
				IDX_SYNC_EN: sync_en_q <= 12'(merge({4'h0, sync_en_q}, 16'h0fff));
				default: ;
			endcase
		end
	end

	// payload grouping per path; full concat wins over the triple bits
	for (genvar i = 0; i < NUM_PATHS; i++) begin : g_mode
		assign gen_path_mode[i] = gen_cfg_q[FULL_BIT] ? MODE_FULL :
			gen_cfg_q[i % GROUPS] ? MODE_TRIPLE : MODE_SINGLE;
		assign chk_path_mode[i] = mon_cfg_q[FULL_BIT] ? MODE_FULL :
			mon_cfg_q[i % GROUPS] ? MODE_TRIPLE : MODE_SINGLE;
	end

	// per-path status flags and error counters
	for (genvar i = 0; i < NUM_PATHS; i++) begin : g_path
		assign hit[i] = path_byte_err_det[i] & path_in_sync_state[i];

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				path_byte_err_flag[i] <= 1'b0;
			end else if (hit[i]) begin
				path_byte_err_flag[i] <= 1'b1;
			end else if (rd && idx == IDX_BERR_STAT) begin
				path_byte_err_flag[i] <= 1'b0;
			end
		end

		// edge of sync state; prev resets to out-of-sync
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				sync_prev_q[i] <= 1'b0;
				path_sync_change_flag[i] <= 1'b0;
			end else begin
				sync_prev_q[i] <= path_in_sync_state[i];
				if (sync_prev_q[i] != path_in_sync_state[i]) begin
					path_sync_change_flag[i] <= 1'b1;
				end else if (rd && idx == IDX_SYNC_STAT) begin
					path_sync_change_flag[i] <= 1'b0;
				end
			end
		end

		// saturating counter, restarts on copy without losing this cycle's hit
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				cnt_q[i] <= RST16;
				hold_q[i] <= RST16;
			end else if (tip_q) begin
				hold_q[i] <= cnt_q[i];
				cnt_q[i] <= {15'h0000, hit[i]};
			end else if (hit[i] && cnt_q[i] != CNT_MAX) begin
				cnt_q[i] <= cnt_q[i] + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(path_byte_err_flag & berr_en_q) | |(path_sync_change_flag & sync_en_q);
		end
	end

	// indirect access decode
	assign path = ram_page_select_q[PATH_LSB +: 4];
	assign page = ram_page_select_q[PAGE_LSB +: 4];
	// only codes 1..12 name a path
	assign path_ok = (path >= PATH_FIRST) && (path <= PATH_LAST);
	// ram pages exclude reserved x011 and every x1xx code
	assign page_ram = ~page[2] & (page[1:0] != PG_RSVD_LO);
	assign page_err = (page == PG_MON_ERR);
	assign path_idx = 4'(path - PATH_FIRST);
	assign ram_idx = {path_idx, page[3], page[1:0]};

	// address write starts access only when idle
	assign acc_start = wr && idx == IDX_RAM_PAGE_SELECT && acc_q == ACC_IDLE;

	// trigger write or indirect write of the error page
	assign xfer_start = (wr && idx == IDX_XFER) ||
		(acc_q == ACC_RUN && !ram_page_select_q[RNW_BIT] && path_ok && page_err);

	// busy lasts one cycle while the RAM is accessed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= ACC_IDLE;
			ram_page_select_q <= RST16;
		end else begin
			unique case (acc_q)
				ACC_IDLE: begin
					if (acc_start) begin
						acc_q <= ACC_RUN;
						ram_page_select_q <= merge(ram_page_select_q, RAM_PAGE_SELECT_MASK);
					end
				end
				ACC_RUN: acc_q <= ACC_IDLE;
			endcase
		end
	end

	// pending high for exactly one copy cycle; retriggers ignored
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tip_q <= 1'b0;
		end else if (tip_q) begin
			tip_q <= 1'b0;
		end else if (xfer_start) begin
			tip_q <= 1'b1;
		end
	end

	assign counter_xfer_pending = tip_q;

	// data register: bus write when idle, RAM read on completion
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_q <= RST16;
		end else if (acc_q == ACC_RUN) begin
			if (ram_page_select_q[RNW_BIT]) begin
				if (!path_ok) begin
					data_q <= RST16;
				end else if (page_ram) begin
					data_q <= ram_q[ram_idx];
				end else if (page_err) begin
					data_q <= hold_q[path_idx];
				end else begin
					data_q <= RST16;
				end
			end
		end else if (wr && idx == IDX_IDATA) begin
			data_q <= merge(data_q, 16'hffff);
		end
	end

	// RAM write; the low LFSR page keeps seven bits only
	always_ff @(posedge clk) begin
		if (acc_q == ACC_RUN && !ram_page_select_q[RNW_BIT] && path_ok && page_ram) begin
			ram_q[ram_idx] <= (page[1:0] == PG_LFSR_LO) ? (data_q & LFSR_LO_MASK) : data_q;
		end
	end

	// read mux; unmapped indices read zero
	always_comb begin
		rdv = RST16;
		unique case (idx)
			IDX_GEN_CFG: rdv = gen_cfg_q;
			IDX_MON_CFG: rdv = mon_cfg_q;
			IDX_BERR_STAT: rdv = {4'h0, path_byte_err_flag};
			IDX_BERR_EN: rdv = {4'h0, berr_en_q};
			IDX_SYNC_STAT: rdv = {4'h0, path_sync_change_flag};
			IDX_SYNC_EN: rdv = {4'h0, sync_en_q};
			IDX_SYNC_ST: rdv = {4'h0, path_in_sync_state};
			IDX_XFER: rdv = {15'h0000, tip_q};
			IDX_RAM_PAGE_SELECT: rdv = {acc_q == ACC_RUN, ram_page_select_q[BUSY_BIT-1:0]};
			IDX_IDATA: rdv = data_q;
			default: rdv = RST16;
		endcase
	end

	// read data registered with the ack, zero otherwise
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_dat_o <= rd ? {16'h0000, rdv} : 32'h0000_0000;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_GEN_FULL: assert property (wr && idx == IDX_GEN_CFG && wb_sel_i[1] && wb_dat_i[FULL_BIT]
		|=> gen_path_mode[11] == MODE_FULL && gen_path_mode[0] == MODE_FULL)
		else $error("full concat did not override generator grouping");
	AST_GEN_TRIPLE: assert property (!gen_cfg_q[FULL_BIT] && gen_cfg_q[2]
		|-> gen_path_mode[2] == MODE_TRIPLE && gen_path_mode[10] == MODE_TRIPLE)
		else $error("paths 3 and 11 not grouped");
	AST_CHK_TRIPLE: assert property (!mon_cfg_q[FULL_BIT] && !mon_cfg_q[3]
		|-> chk_path_mode[7] == MODE_SINGLE)
		else $error("monitor path 8 wrongly grouped");
	AST_BERR_SET: assert property (hit[4] |=> path_byte_err_flag[4])
		else $error("byte error flag not set");
	AST_BERR_CLR: assert property (rd && idx == IDX_BERR_STAT && hit == '0
		|=> path_byte_err_flag == '0)
		else $error("byte error flags not cleared by read");
	AST_IRQ: assert property (path_byte_err_flag[0] && berr_en_q[0] |=> irq_o)
		else $error("enabled byte error did not raise interrupt");
	AST_IRQ_OFF: assert property (path_byte_err_flag == '0 && path_sync_change_flag == '0
		|=> !irq_o)
		else $error("interrupt without flag");
	AST_SYNC_CHG: assert property (path_in_sync_state[9] != $past(path_in_sync_state[9])
		|=> path_sync_change_flag[9])
		else $error("sync change not flagged");
	AST_TIP: assert property (wr && idx == IDX_XFER && !tip_q
		|=> tip_q ##1 !tip_q && hold_q[0] == $past(cnt_q[0]))
		else $error("counter transfer sequence wrong");
	AST_TIP_RD: assert property (rd && idx == IDX_XFER |=> wb_dat_o[0] == $past(tip_q))
		else $error("pending bit read mismatch");
	AST_BUSY: assert property (acc_start |=> acc_q == ACC_RUN ##1 acc_q == ACC_IDLE)
		else $error("busy sequence wrong");
	AST_BAD_PATH: assert property (acc_q == ACC_RUN && ram_page_select_q[RNW_BIT] && !path_ok
		|=> data_q == RST16)
		else $error("invalid path returned data");
	AST_SAT: assert property (cnt_q[1] == CNT_MAX && !tip_q |=> cnt_q[1] == CNT_MAX)
		else $error("counter wrapped");
	AST_NO_CORRUPT: assert property (acc_q == ACC_RUN |=> $stable(ram_page_select_q))
		else $error("address changed during access");

	COV_XFER: cover property (wr && idx == IDX_XFER ##1 tip_q ##1 !tip_q);
	COV_IRD: cover property (acc_start && wb_dat_i[RNW_BIT] ##2 data_q != RST16);
	COV_IRQ: cover property (!irq_o ##1 irq_o);
	COV_SYNC: cover property (path_sync_change_flag[0] && sync_en_q[0]);
endmodule
`default_nettype wire

// *** ppt_path_test_ctrl_bench.sv ***
`default_nettype none
module ppt_path_test_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import ppt_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [9:0] wb_adr_i = 10'h000;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [NUM_PATHS-1:0] want_sync = '0;
	logic [NUM_PATHS-1:0] want_err = '0;
	logic [NUM_PATHS-1:0] path_in_sync_state;
	logic [NUM_PATHS-1:0] path_byte_err_det;
	ppt_mode_type [NUM_PATHS-1:0] gen_path_mode;
	ppt_mode_type [NUM_PATHS-1:0] chk_path_mode;
	logic irq_o;
	logic counter_xfer_pending;
	logic pend_seen;
	logic [15:0] rd;
	int fails = 0;
	int checks = 0;
	logic [7:0] rst_idx [6] = '{IDX_GEN_CFG, IDX_MON_CFG, IDX_BERR_EN, IDX_SYNC_EN,
		IDX_XFER, IDX_RAM_PAGE_SELECT};
	// indirect page table: page, path, data written, data read back
	logic [3:0] tpg [9] = '{4'h1, 4'h2, 4'h0, 4'h8, 4'h9, 4'ha, 4'h0, 4'h3, 4'hb};
	logic [3:0] tpt [9] = '{4'hc, 4'h1, 4'h7, 4'h6, 4'h4, 4'h4, 4'hd, 4'h2, 4'h1};
	logic [15:0] twd [9] = '{16'h1234, 16'hffff, 16'h0005, 16'h00ff, 16'ha5a5,
		16'hffff, 16'h5555, 16'h5555, 16'h5555};
	logic [15:0] tex [9] = '{16'h1234, 16'h007f, 16'h0005, 16'h00ff, 16'ha5a5,
		16'h007f, 16'h0000, 16'h0000, 16'h0000};
	always #50 clk = ~clk;
	ppt_path_test_ctrl dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_cyc_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.path_in_sync_state(path_in_sync_state), .path_byte_err_det(path_byte_err_det),
		.gen_path_mode(gen_path_mode), .chk_path_mode(chk_path_mode), .irq_o(irq_o),
		.counter_xfer_pending(counter_xfer_pending));
	ppt_link_model link (.clk(clk), .rst_n(rst_n), .want_sync(want_sync),
		.want_err(want_err), .path_in_sync_state(path_in_sync_state),
		.path_byte_err_det(path_byte_err_det));
	task automatic tally_and_finish;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask
	// one classic cycle; request held until ack is seen at a rising edge
	task automatic wb(input logic we, input logic [7:0] idx, input logic [15:0] wd,
		input logic [3:0] sel);
		wb_cyc_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= sel;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= {16'h0000, wd};
		// no fixed latency assumed; only the watchdog ends a stuck wait
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		chk_bit(wb_ack_o, 1'b1);
		rd = wb_dat_o[15:0];
		pend_seen = counter_xfer_pending;
		wb_cyc_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [15:0] exp);
		wb(1'b0, idx, 16'h0000, 4'h3);
		chk(rd, exp);
	endtask
	// start an indirect access, then confirm it has finished and fields read back
	task automatic ind(input logic rnw, input logic [3:0] pg, input logic [3:0] pt);
		logic [15:0] a;
		a = {1'b0, rnw, 4'h0, pg, 2'b00, pt};
		wb(1'b1, IDX_RAM_PAGE_SELECT, a, 4'h3);
		rdchk(IDX_RAM_PAGE_SELECT, a);
	endtask
	task automatic chk_modes(input logic [15:0] cfg, input logic gen);
		ppt_mode_type e;
		for (int i = 0; i < NUM_PATHS; i++) begin
			e = cfg[FULL_BIT] ? MODE_FULL : (cfg[i % GROUPS] ? MODE_TRIPLE : MODE_SINGLE);
			chk(16'(gen ? gen_path_mode[i] : chk_path_mode[i]), 16'(e));
		end
	endtask
	task automatic hit(input logic [11:0] m, input int n);
		want_err <= m;
		repeat (n) @(posedge clk);
		want_err <= '0;
		repeat (4) @(posedge clk);
	endtask
	// hang guard, well beyond the saturation burst
	initial begin
		repeat (90000) @(posedge clk);
		fails++;
		tally_and_finish;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (rst_idx[i]) rdchk(rst_idx[i], 16'h0000);
		wb(1'b1, IDX_GEN_CFG, 16'h0005, 4'h3);
		chk_modes(16'h0005, 1'b1);
		wb(1'b1, IDX_GEN_CFG, 16'h4005, 4'h3);
		chk_modes(16'h4005, 1'b1);
		wb(1'b1, IDX_MON_CFG, 16'h000a, 4'h3);
		chk_modes(16'h000a, 1'b0);
		wb(1'b1, IDX_MON_CFG, 16'h400a, 4'h3);
		chk_modes(16'h400a, 1'b0);
		// path 3 locks; path 1 stays out of lock
		want_sync <= 12'h004;
		repeat (4) @(posedge clk);
		rdchk(IDX_SYNC_ST, 16'h0004);
		rdchk(IDX_SYNC_STAT, 16'h0004);
		rdchk(IDX_SYNC_STAT, 16'h0000);
		hit(12'h005, 1);
		rdchk(IDX_BERR_STAT, 16'h0004);
		chk_bit(irq_o, 1'b0);
		wb(1'b1, IDX_BERR_EN, 16'h0004, 4'h3);
		hit(12'h004, 1);
		chk_bit(irq_o, 1'b1);
		rdchk(IDX_BERR_STAT, 16'h0004);
		repeat (3) @(posedge clk);
		chk_bit(irq_o, 1'b0);
		wb(1'b1, IDX_SYNC_EN, 16'h0010, 4'h3);
		want_sync <= 12'h014;
		repeat (4) @(posedge clk);
		chk_bit(irq_o, 1'b1);
		rdchk(IDX_SYNC_STAT, 16'h0010);
		want_sync <= 12'h004;
		repeat (4) @(posedge clk);
		rdchk(IDX_SYNC_STAT, 16'h0010);
		repeat (3) @(posedge clk);
		chk_bit(irq_o, 1'b0);
		wb(1'b1, IDX_SYNC_EN, 16'h0fff, 4'h2);
		rdchk(IDX_SYNC_EN, 16'h0f10);
		wb(1'b1, IDX_SYNC_ST, 16'hffff, 4'h3);
		rdchk(IDX_SYNC_ST, 16'h0004);
		// two errors counted on path 3 so far
		wb(1'b1, IDX_XFER, 16'h5a5a, 4'h3);
		chk_bit(pend_seen, 1'b1);
		rdchk(IDX_XFER, 16'h0000);
		ind(1'b1, PG_MON_ERR, 4'h3);
		rdchk(IDX_IDATA, 16'h0002);
		foreach (tpg[i]) begin
			wb(1'b1, IDX_IDATA, twd[i], 4'h3);
			ind(1'b0, tpg[i], tpt[i]);
			wb(1'b1, IDX_IDATA, ~twd[i], 4'h3);
			ind(1'b1, tpg[i], tpt[i]);
			rdchk(IDX_IDATA, tex[i]);
		end
		// counter must stop at its top value, then restart after a transfer
		hit(12'h004, 65540);
		wb(1'b1, IDX_XFER, 16'h0000, 4'h3);
		ind(1'b1, PG_MON_ERR, 4'h3);
		rdchk(IDX_IDATA, CNT_MAX);
		ind(1'b0, PG_MON_ERR, 4'h3);
		ind(1'b1, PG_MON_ERR, 4'h3);
		rdchk(IDX_IDATA, 16'h0000);
		wb(1'b1, 8'h10, 16'hffff, 4'h3);
		rdchk(8'h10, 16'h0000);
		tally_and_finish;
	end
endmodule
`default_nettype wire

// *** ppt_pkg.sv ***
`default_nettype none
package ppt_pkg;
	localparam int NUM_PATHS = 12;
	localparam int GROUPS = 4;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_GEN_CFG = 8'h72;
	localparam logic [7:0] IDX_MON_CFG = 8'h73;
	localparam logic [7:0] IDX_BERR_STAT = 8'h74;
	localparam logic [7:0] IDX_BERR_EN = 8'h75;
	localparam logic [7:0] IDX_SYNC_STAT = 8'h79;
	localparam logic [7:0] IDX_SYNC_EN = 8'h7a;
	localparam logic [7:0] IDX_SYNC_ST = 8'h7b;
	localparam logic [7:0] IDX_XFER = 8'h7c;
	localparam logic [7:0] IDX_RAM_PAGE_SELECT = 8'h80;
	localparam logic [7:0] IDX_IDATA = 8'h81;
	// field layout
	localparam int FULL_BIT = 14;
	localparam int BUSY_BIT = 15;
	localparam int RNW_BIT = 14;
	localparam int PAGE_LSB = 6;
	localparam int PATH_LSB = 0;
	localparam logic [15:0] GEN_CFG_MASK = 16'hc70f;
	localparam logic [15:0] MON_CFG_MASK = 16'hc74f;
	localparam logic [15:0] RAM_PAGE_SELECT_MASK = 16'h43cf;
	localparam logic [15:0] LFSR_LO_MASK = 16'h007f;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] RST16 = 16'h0000;
	// path and page codes
	localparam logic [3:0] PATH_FIRST = 4'h1;
	localparam logic [3:0] PATH_LAST = 4'hc;
	localparam logic [3:0] PG_MON_ERR = 4'h4;
	localparam logic [1:0] PG_RSVD_LO = 2'h3;
	localparam logic [1:0] PG_LFSR_LO = 2'h2;
	localparam int RAM_SLOTS = 8;
	typedef enum logic [1:0] {MODE_SINGLE, MODE_TRIPLE, MODE_FULL} ppt_mode_type;
	typedef enum logic {ACC_IDLE, ACC_RUN} ppt_acc_type;
endpackage
`default_nettype wire
